//--- xy_space_pkg.sv
// Constants and types for the X/Y data space access path
// Assumes a 16-bit core with byte addresses and word-wide data RAM
// Contract
// R1: Two data spaces X and Y, separate for dual ops, unified for others; the X read unit also reads the Y bank in dual ops.
// R2: Two independent address units with own data paths allow two-word reads.
// R3: X space serves every instruction and every addressing mode.
// R4: X space has physically distinct read and write buses.
// R5: Unified-range reads return their data over the X read bus.
// R6: X read bus is also the X operand prefetch path for dual ops.
// R7: Multiply-accumulate class ops get a concurrent second read from Y.
// R8: Both X and Y spaces support modulo addressing for all instructions; the code applies the Y buffer bounds only to Y unit reads in dual ops.
// R9: Bit-reversed addressing applies only to writes into X space.
// R10: Every write is decoded against the combined X plus Y range.
// R11: The X/Y boundary is a fixed constant; software cannot move it.
// R12: Unified accesses pick X or Y bank by boundary compare, return that word.
package xy_space_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int IDX_W = 9;
	localparam int BANK_WORDS = 512;

	// Data RAM window, X from the base, Y from the fixed boundary
	localparam logic [15:0] RAM_BASE = 16'h1000;
	localparam logic [15:0] Y_BASE = 16'h1400;
	localparam logic [15:0] RAM_LAST = 16'h17FF;
	localparam logic [15:0] DATA_RST = 16'h0000;

	typedef enum logic [1:0] {
		mode_direct = 2'h0,
		mode_indirect = 2'h1,
		mode_modulo = 2'h2,
		mode_bitrev = 2'h3
	} mode_t;

	typedef enum logic [3:0] {
		op_plain = 4'h0,
		clear_accumulator_op = 4'h1,
		euclidean_distance_op = 4'h2,
		euclidean_distance_accumulate_op = 4'h3,
		multiply_accumulate_op = 4'h4,
		prefetch_store_accumulator_op = 4'h5,
		multiply_to_accumulator_op = 4'h6,
		negated_multiply_op = 4'h7,
		multiply_subtract_op = 4'h8
	} op_t;

endpackage

//--- dual_data_space_access.sv
// X/Y data space access: three address units, two banks, registered reads
// Assumes the core holds requests for one cycle and takes data a cycle later
`timescale 1ns/1ps

module dual_data_space_access
(
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire xy_space_pkg::op_t op, // Class of the current instruction
	input wire logic xr_req, // X read bus request
	input wire logic [15:0] xr_base, // X read pointer
	input wire logic [15:0] xr_offset, // X read offset
	input wire xy_space_pkg::mode_t xr_mode, // X read addressing mode
	input wire logic wr_req, // X write bus request
	input wire logic [15:0] wr_base, // Write pointer
	input wire logic [15:0] wr_offset, // Write offset
	input wire xy_space_pkg::mode_t wr_mode, // Write addressing mode
	input wire logic [15:0] wr_data, // Write data
	input wire logic [3:0] br_bits, // Bit-reversed field width
	input wire logic [15:0] xmod_start, // X modulo buffer first word
	input wire logic [15:0] xmod_end, // X modulo buffer last word
	input wire logic yr_req, // Y read request
	input wire logic [15:0] yr_base, // Y read pointer
	input wire logic [15:0] yr_offset, // Y read offset
	input wire xy_space_pkg::mode_t yr_mode, // Y read addressing mode
	input wire logic [15:0] ymod_start, // Y modulo buffer first word
	input wire logic [15:0] ymod_end, // Y modulo buffer last word
	output logic [15:0] x_rdata, // X read bus data
	output logic x_rvalid, // X read data valid pulse
	output logic [15:0] y_rdata, // Y read data
	output logic y_rvalid, // Y read data valid pulse
	output logic range_err // Access outside its space, pulse
);
	import xy_space_pkg::*;

	// Effective address: linear, circular wrap, or bit-reversed pointer
	function automatic logic [15:0] ea_calc(input logic [15:0] base,
		input logic [15:0] offset, input mode_t mode,
		input logic [15:0] mstart, input logic [15:0] mend,
		input logic [3:0] bits, input logic allow_br);
		logic [15:0] r;
		logic [15:0] span;
		r = base + offset;
		span = mend - mstart + 16'h0002;
		case (mode)
			mode_modulo:
			begin
				if (r > mend)
					r = r - span;
				else if (r < mstart)
					r = r + span;
			end
			mode_bitrev:
			begin
				if (allow_br)
				begin
					r = base;
					for (int i = 0; i < 15; i++)
						if (i < int'(bits))
							r[i + 1] = base[int'(bits) - i];
				end
			end
			default:
			begin
				r = base + offset;
			end
		endcase
		r[0] = 1'b0;
		return r;
	endfunction

	// Address falls inside data RAM at all
	function automatic logic in_ram(input logic [15:0] a);
		return (a >= RAM_BASE) && (a <= RAM_LAST);
	endfunction

	// Address lies at or above the fixed X/Y boundary, up to the end of data RAM
	function automatic logic in_y(input logic [15:0] a);
		return (a >= Y_BASE) && (a <= RAM_LAST);
	endfunction

	// Word index inside a bank
	function automatic logic [8:0] bank_idx(input logic [15:0] a);
		logic [15:0] d;
		d = in_y(a) ? (a - Y_BASE) : (a - RAM_BASE);
		return d[9:1];
	endfunction

	// Instruction classes that get a second concurrent operand
	function automatic logic is_dual_op(input op_t o);
		return (o == clear_accumulator_op) || (o == euclidean_distance_op)
			|| (o == euclidean_distance_accumulate_op)
			|| (o == multiply_accumulate_op)
			|| (o == prefetch_store_accumulator_op)
			|| (o == multiply_to_accumulator_op)
			|| (o == negated_multiply_op)
			|| (o == multiply_subtract_op);
	endfunction

	logic [15:0] x_mem [BANK_WORDS];
	logic [15:0] y_mem [BANK_WORDS];
	logic [15:0] xr_ea;
	logic [15:0] wr_ea;
	logic [15:0] yr_ea;
	logic dual;
	logic wr_br_ok;
	logic [15:0] x_rdata_d, x_rdata_q;
	logic [15:0] y_rdata_d, y_rdata_q;
	logic x_rvalid_d, x_rvalid_q;
	logic y_rvalid_d, y_rvalid_q;
	logic range_err_d, range_err_q;

	// Three address units; only the write unit may bit-reverse into X
	always_comb
	begin
		dual = is_dual_op(op);
		wr_br_ok = in_ram(wr_base) && !in_y(wr_base); // [R9]
		xr_ea = ea_calc(xr_base, xr_offset, xr_mode, xmod_start, xmod_end,
			br_bits, 1'b0); // [R3] [R8] [R9]
		wr_ea = ea_calc(wr_base, wr_offset, wr_mode, xmod_start, xmod_end,
			br_bits, wr_br_ok); // [R3] [R8] [R9]
		yr_ea = ea_calc(yr_base, yr_offset, yr_mode, ymod_start, ymod_end,
			br_bits, 1'b0); // [R2] [R8] [R9]
	end

	// Read paths and error flag next values
	always_comb
	begin
		x_rdata_d = x_rdata_q;
		y_rdata_d = y_rdata_q;
		x_rvalid_d = xr_req;
		y_rvalid_d = yr_req && dual; // [R7]
		if (xr_req)
		begin
			// Unified range read, bank picked by the boundary [R5] [R6] [R12]
			if (!in_ram(xr_ea))
				x_rdata_d = DATA_RST;
			else if (in_y(xr_ea))
				x_rdata_d = y_mem[bank_idx(xr_ea)]; // [R1] [R11]
			else
				x_rdata_d = x_mem[bank_idx(xr_ea)];
		end
		if (yr_req && dual)
		begin
			// Second operand only from the Y bank [R1] [R2] [R7]
			if (in_y(yr_ea))
				y_rdata_d = y_mem[bank_idx(yr_ea)];
			else
				y_rdata_d = DATA_RST;
		end
		range_err_d = (xr_req && !in_ram(xr_ea))
			|| (wr_req && !in_ram(wr_ea))
			|| (yr_req && dual && !in_y(yr_ea));
	end

	// Output registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			x_rdata_q <= DATA_RST;
			y_rdata_q <= DATA_RST;
			x_rvalid_q <= 1'b0;
			y_rvalid_q <= 1'b0;
			range_err_q <= 1'b0;
		end
		else
		begin
			x_rdata_q <= x_rdata_d;
			y_rdata_q <= y_rdata_d;
			x_rvalid_q <= x_rvalid_d;
			y_rvalid_q <= y_rvalid_d;
			range_err_q <= range_err_d;
		end
	end

	// Separate write bus, decoded over the combined range
	always_ff @(posedge clk)
	begin
		if (wr_req && in_ram(wr_ea)) // [R4]
		begin
			if (in_y(wr_ea)) // [R10] [R12]
				y_mem[bank_idx(wr_ea)] <= wr_data;
			else
				x_mem[bank_idx(wr_ea)] <= wr_data;
		end
	end

	assign x_rdata = x_rdata_q;
	assign y_rdata = y_rdata_q;
	assign x_rvalid = x_rvalid_q;
	assign y_rvalid = y_rvalid_q;
	assign range_err = range_err_q;

	// Checks on the access path
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	x_read_valid_a: assert property (xr_req |=> x_rvalid) // [R5]
		else $error("X read not answered next cycle");
	dual_read_a: assert property (xr_req && yr_req && dual
		|=> x_rvalid && y_rvalid) // [R2] [R6] [R7]
		else $error("Dual operand reads not concurrent");
	y_refused_a: assert property (yr_req && !dual |=> !y_rvalid) // [R7]
		else $error("Y read granted to a plain instruction");
	rw_apart_a: assert property (xr_req && wr_req |=> x_rvalid) // [R4]
		else $error("Write blocked the X read bus");
	no_br_read_a: assert property (xr_req && xr_mode == mode_bitrev
		|-> xr_ea == ((xr_base + xr_offset) & 16'hFFFE)) // [R9]
		else $error("Bit reversal applied to a read");
	modulo_in_a: assert property (xr_req && xr_mode == mode_modulo
		&& xmod_start <= xmod_end && xr_base >= xmod_start
		&& xr_base <= xmod_end && xr_offset <= 16'h0002
		|-> xr_ea >= (xmod_start & 16'hFFFE) && xr_ea <= xmod_end) // [R8]
		else $error("Modulo address left its buffer");
	outside_zero_a: assert property (xr_req && !in_ram(xr_ea)
		|=> x_rdata == DATA_RST && range_err) // [R12]
		else $error("Out of range read not flagged");
	y_write_back_a: assert property (wr_req && in_y(wr_ea) && !xr_req
		##1 xr_req && xr_ea == $past(wr_ea) && !wr_req
		|=> x_rdata == $past(wr_data, 2)) // [R10] [R12]
		else $error("Y write not seen through unified read");
	y_dual_back_a: assert property (wr_req && in_y(wr_ea)
		##1 yr_req && dual && yr_ea == $past(wr_ea) && !wr_req
		|=> y_rdata == $past(wr_data, 2)) // [R1] [R10]
		else $error("Y write not seen by dual operand read");

endmodule // dual_data_space_access

//--- core_model.sv
// Core-side model: issues X/Y read and write requests
// Assumes callers run in step with clk; each request lasts one edge
`timescale 1ns/1ps

module core_model
(
	input wire logic clk, // Core clock
	output xy_space_pkg::op_t op, // Class
	output logic xr_req, // X read
	output logic [15:0] xr_base, // X pointer
	output logic [15:0] xr_offset, // X offset
	output xy_space_pkg::mode_t xr_mode, // X mode
	output logic wr_req, // Write
	output logic [15:0] wr_base, // Write pointer
	output logic [15:0] wr_offset, // Write offset
	output xy_space_pkg::mode_t wr_mode, // Write mode
	output logic [15:0] wr_data, // Write data
	output logic [3:0] br_bits, // Reversed width
	output logic [15:0] xmod_start, // X buffer first
	output logic [15:0] xmod_end, // X buffer last
	output logic yr_req, // Y read
	output logic [15:0] yr_base, // Y pointer
	output logic [15:0] yr_offset, // Y offset
	output xy_space_pkg::mode_t yr_mode, // Y mode
	output logic [15:0] ymod_start, // Y buffer first
	output logic [15:0] ymod_end // Y buffer last
);
	import xy_space_pkg::*;

	// Fixed buffer bounds and reversed field width
	assign br_bits = 4'h2;
	assign xmod_start = 16'h1000;
	assign xmod_end = 16'h100E;
	assign ymod_start = 16'h1400;
	assign ymod_end = 16'h140E;

	// Idle values at time zero
	initial
	begin
		{xr_req, wr_req, yr_req} = 3'h0;
		op = op_plain;
		xr_mode = mode_direct;
		wr_mode = mode_direct;
		yr_mode = mode_direct;
		{xr_base, xr_offset, wr_base, wr_offset} = 64'h0;
		{wr_data, yr_base, yr_offset} = 48'h0;
	end

	// One write, held for one edge; data scrambled once released
	task automatic wr(input logic [15:0] a, input logic [15:0] d,
		input mode_t m);
		@(posedge clk);
		#1 wr_req = 1'b1;
		wr_base = a;
		wr_mode = m;
		wr_data = d;
		@(posedge clk);
		#1 wr_req = 1'b0;
		wr_data = ~d;
	endtask

	// X and Y reads issued together under one class
	task automatic rd(input logic [15:0] xa, input logic [15:0] xo,
		input logic [15:0] ya, input mode_t m, input op_t o);
		@(posedge clk);
		#1 xr_req = 1'b1;
		yr_req = 1'b1;
		xr_base = xa;
		xr_offset = xo;
		yr_base = ya;
		yr_offset = xo;
		xr_mode = m;
		yr_mode = m;
		op = o;
		@(posedge clk);
		#1 xr_req = 1'b0;
		yr_req = 1'b0;
		xr_base = ~xa;
		yr_base = ~ya;
	endtask

	// Write, then both units read that address on the very next edge
	task automatic wr_then_rd(input logic [15:0] a, input logic [15:0] d,
		input op_t o);
		@(posedge clk);
		#1 wr_req = 1'b1;
		wr_base = a;
		wr_mode = mode_direct;
		wr_data = d;
		@(posedge clk);
		#1 wr_req = 1'b0;
		wr_data = ~d;
		xr_req = 1'b1;
		yr_req = 1'b1;
		xr_base = a;
		xr_offset = 16'h0000;
		yr_base = a;
		yr_offset = 16'h0000;
		xr_mode = mode_direct;
		yr_mode = mode_direct;
		op = o;
		@(posedge clk);
		#1 xr_req = 1'b0;
		yr_req = 1'b0;
		xr_base = ~a;
		yr_base = ~a;
	endtask

	// X read and write on the same edge over the two X buses
	task automatic rd_wr(input logic [15:0] ra, input logic [15:0] wa,
		input logic [15:0] d);
		@(posedge clk);
		#1 xr_req = 1'b1;
		xr_base = ra;
		xr_offset = 16'h0000;
		xr_mode = mode_direct;
		wr_req = 1'b1;
		wr_base = wa;
		wr_mode = mode_direct;
		wr_data = d;
		@(posedge clk);
		#1 xr_req = 1'b0;
		wr_req = 1'b0;
		xr_base = ~ra;
		wr_data = ~d;
	endtask
endmodule // core_model

//--- dual_data_space_access_test.sv
// Self-checking bench for the X/Y data space access path
// Assumes core_model drives every request input of the design
`timescale 1ns/1ps

module dual_data_space_access_test;
	import xy_space_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	op_t op;
	mode_t xr_mode, wr_mode, yr_mode;
	logic xr_req, wr_req, yr_req, x_rvalid, y_rvalid, range_err;
	logic [15:0] xr_base, xr_offset, wr_base, wr_offset, wr_data;
	logic [15:0] xmod_start, xmod_end, yr_base, yr_offset;
	logic [15:0] ymod_start, ymod_end, x_rdata, y_rdata;
	logic [3:0] br_bits;
	int n_errors = 0;
	int samples_checked = 0;

	always #50 clk = ~clk;

	core_model core_u (.clk, .op, .xr_req, .xr_base, .xr_offset, .xr_mode,
		.wr_req, .wr_base, .wr_offset, .wr_mode, .wr_data, .br_bits,
		.xmod_start, .xmod_end, .yr_req, .yr_base, .yr_offset, .yr_mode,
		.ymod_start, .ymod_end);
	dual_data_space_access dut_u (.clk, .sys_rst, .op, .xr_req, .xr_base,
		.xr_offset, .xr_mode, .wr_req, .wr_base, .wr_offset, .wr_mode,
		.wr_data, .br_bits, .xmod_start, .xmod_end, .yr_req, .yr_base,
		.yr_offset, .yr_mode, .ymod_start, .ymod_end, .x_rdata, .x_rvalid,
		.y_rdata, .y_rvalid, .range_err);

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Verdict and end of run
	task automatic stop_test();
		if (n_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Plain write then plain read on X; Y refused for plain class
	task automatic t_plain();
		core_u.wr(16'h1010, 16'hA5A5, mode_direct);
		core_u.rd(16'h1010, 16'h0000, 16'h1400, mode_direct,
			op_plain);
		chk(x_rvalid, 16'h0001);
		chk(x_rdata, 16'hA5A5);
		chk(y_rvalid, 16'h0000);
	endtask

	// Every dual class gets both words; X reads a Y address too
	task automatic t_dual();
		core_u.wr(16'h1400, 16'h5A5A, mode_direct);
		for (int i = 1; i <= 8; i++)
		begin
			core_u.rd(16'h1010, 16'h0000, 16'h1400, mode_direct,
				op_t'(i));
			chk(x_rdata, 16'hA5A5);
			chk(y_rvalid, 16'h0001);
			chk(y_rdata, 16'h5A5A);
		end
		core_u.rd(16'h1400, 16'h0000, 16'h1400, mode_direct,
			op_plain);
		chk(x_rdata, 16'h5A5A);
		chk(range_err, 16'h0000);
		// Y write read back on the very next edge by both units
		core_u.wr_then_rd(16'h1406, 16'hC3C3,
			euclidean_distance_op);
		chk(x_rdata, 16'hC3C3);
		chk(y_rdata, 16'hC3C3);
	endtask

	// Circular buffers wrap past their last word in both spaces
	task automatic t_modulo();
		core_u.wr(16'h1000, 16'h1234, mode_direct);
		core_u.rd(16'h100C, 16'h0004, 16'h140C, mode_modulo,
			multiply_subtract_op);
		chk(x_rdata, 16'h1234);
		chk(y_rdata, 16'h5A5A);
		// Pointer on the last word, one word step wraps to the first
		core_u.rd(16'h100E, 16'h0002, 16'h140E, mode_modulo,
			multiply_subtract_op);
		chk(x_rdata, 16'h1234);
		chk(y_rdata, 16'h5A5A);
		// Write unit wraps as well
		core_u.wr(16'h1010, 16'h7777, mode_modulo);
		core_u.rd(16'h1000, 16'h0000, 16'h1400, mode_direct,
			op_plain);
		chk(x_rdata, 16'h7777);
	endtask

	// Reversal only for X writes, never reads or Y writes
	task automatic t_bitrev();
		core_u.wr(16'h1002, 16'h0000, mode_direct);
		core_u.wr(16'h1402, 16'h1111, mode_direct);
		core_u.wr(16'h1002, 16'hBEEF, mode_bitrev);
		core_u.rd(16'h1002, 16'h0000, 16'h1402, mode_bitrev,
			multiply_accumulate_op);
		chk(x_rdata, 16'h0000);
		chk(y_rdata, 16'h1111);
		core_u.wr(16'h1402, 16'h2222, mode_bitrev);
		core_u.rd(16'h1004, 16'h0000, 16'h1402, mode_direct,
			multiply_accumulate_op);
		chk(x_rdata, 16'hBEEF);
		chk(y_rdata, 16'h2222);
		// Read and write on one edge do not block each other
		core_u.rd_wr(16'h1004, 16'h1008, 16'h6666);
		chk(x_rvalid, 16'h0001);
		chk(x_rdata, 16'hBEEF);
		core_u.rd(16'h1008, 16'h0000, 16'h1402, mode_direct,
			op_plain);
		chk(x_rdata, 16'h6666);
	endtask

	// Reset in mid-run clears the read registers, not the banks
	task automatic t_reset();
		@(posedge clk);
		#1 sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		chk(x_rdata, DATA_RST);
		chk(y_rdata, DATA_RST);
		chk(x_rvalid, 16'h0000);
		core_u.rd(16'h1004, 16'h0000, 16'h1402, mode_indirect,
			multiply_accumulate_op);
		chk(x_rdata, 16'hBEEF);
		chk(y_rdata, 16'h2222);
		@(posedge clk);
		#1 chk(x_rvalid, 16'h0000);
	endtask

	// Below RAM and Y unit below the boundary both fail
	task automatic t_range();
		core_u.rd(16'h0FFE, 16'h0000, Y_BASE - 16'h0002, mode_direct,
			clear_accumulator_op);
		chk(x_rdata, 16'h0000);
		chk(y_rdata, 16'h0000);
		chk(range_err, 16'h0001);
	endtask

	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		#1 sys_rst = 1'b0;
		t_plain();
		t_dual();
		t_modulo();
		t_bitrev();
		t_reset();
		t_range();
		stop_test();
	end

	// Watchdog against a hang
	initial
	begin
		repeat (500) @(posedge clk);
		n_errors++;
		stop_test();
	end
endmodule // dual_data_space_access_test
